// ### acf_pkg.sv
`default_nettype none
package acf_pkg;
	// frame control bytes
	localparam logic [7:0] CH_ENQ = 8'h05;
	localparam logic [7:0] CH_ACK = 8'h06;
	localparam logic [7:0] CH_NAK = 8'h15;
	localparam logic [7:0] CH_EOT = 8'h04;
	localparam logic [7:0] CH_ETX = 8'h03;
	localparam logic [7:0] CH_PCT = 8'h25;
	// main instruction letters, upper-case form
	localparam logic [7:0] INS_READ = 8'h52;
	localparam logic [7:0] INS_WRITE = 8'h57;
	localparam logic [7:0] INS_MON_REG = 8'h58;
	localparam logic [7:0] INS_MON_RUN = 8'h59;
	// instruction type codes
	localparam logic [15:0] TYP_SINGLE = 16'h5353;
	localparam logic [15:0] TYP_BLOCK = 16'h5342;
	localparam logic [15:0] TYP_STATUS = 16'h5354;
	// block count range
	localparam logic [7:0] BLK_MIN = 8'h01;
	localparam logic [7:0] BLK_MAX = 8'h10;
	localparam logic [1:0] BLK_CHARS = 2'h2;
	// character classes
	localparam logic [7:0] CASE_BIT = 8'h20;
	localparam logic [7:0] LOW_A = 8'h61;
	localparam logic [7:0] LOW_Z = 8'h7A;
	localparam logic [7:0] DIG_0 = 8'h30;
	localparam logic [7:0] DIG_9 = 8'h39;
	localparam logic [7:0] UP_A = 8'h41;
	localparam logic [7:0] UP_F = 8'h46;
	localparam logic [3:0] TEN = 4'hA;
	// fault codes carried in a locally generated negative answer
	localparam logic [15:0] ERR_INSTR = 16'h0001;
	localparam logic [15:0] ERR_TYPE = 16'h0002;
	localparam logic [15:0] ERR_BLOCKS = 16'h0003;
	localparam logic [15:0] ERR_CHECK = 16'h0004;
	localparam logic [1:0] ERR_LAST = 2'h3;

	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_READ_SINGLE_CMD = 3'b001,
		OP_READ_BLOCK_CMD = 3'b010,
		OP_WRITE_SINGLE_CMD = 3'b011,
		OP_WRITE_BLOCK_CMD = 3'b100,
		OP_MON_REGISTER = 3'b101,
		OP_MON_EXECUTE = 3'b110,
		OP_STATUS = 3'b111
	} acf_op_t;

	typedef struct packed {
		acf_op_t op;
		logic checked;
		logic [15:0] station;
		logic [7:0] main;
		logic [15:0] typ;
		logic [7:0] blocks;
		logic fault;
		logic [15:0] err;
	} acf_cmd_t;

	typedef struct packed {
		logic [7:0] data;
		logic addr_start;
	} acf_pay_t;

	typedef struct packed {
		logic [7:0] data;
		logic last;
		logic nak;
	} acf_rsp_t;

	function automatic logic is_lower(input logic [7:0] c);
		return (c >= LOW_A) && (c <= LOW_Z);
	endfunction

	function automatic logic [7:0] to_upper(input logic [7:0] c);
		return is_lower(c) ? (c & ~CASE_BIT) : c;
	endfunction

	function automatic logic is_hex(input logic [7:0] c);
		return ((c >= DIG_0) && (c <= DIG_9)) || ((c >= UP_A) && (c <= UP_F));
	endfunction

	function automatic logic [3:0] hex_val(input logic [7:0] c);
		logic [7:0] v;
		v = (c <= DIG_9) ? (c - DIG_0) : (c - UP_A + 8'(TEN));
		return v[3:0];
	endfunction

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		return (n < TEN) ? (DIG_0 + 8'(n)) : (UP_A + 8'(n - TEN));
	endfunction
endpackage
`default_nettype wire

// ### acf_fcs.sv
`timescale 1ns/1ps
`default_nettype none
module acf_fcs (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic add,
	input wire logic [7:0] data,
	output logic [7:0] sum
);
	logic [7:0] sum_q;
	logic [7:0] sum_d;

	// only the low byte of the running sum is kept, carries fall away
	always_comb begin
		sum_d = sum_q;
		if (load) begin
			sum_d = data;
		end else if (add) begin
			sum_d = sum_q + data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sum_q <= 8'h00;
		end else begin
			sum_q <= sum_d;
		end
	end

	assign sum = sum_q;
endmodule
`default_nettype wire

// ### acf_frames.sv
// Notes on behaviour
// - a request starts at the enquiry byte; it restarts any partial request
// - a clean request is answered with a frame opening with acknowledge, or with not-acknowledge if the user's first answer byte sets nak
// - a faulty request is answered with a frame opening with not-acknowledge
// - the end-of-transmission byte closes a request
// - every answer frame closes with the end-of-text byte
// - read plus single type code selects single-item read
// - read plus block type code selects block read
// - write plus single type code selects single-item write
// - write plus block type code selects block write
// - letter x registers a monitoring set, no type field
// - letter y runs the registered monitoring set, no type field
// - read plus status type code asks for cpu status
// - letter case is ignored everywhere except the main instruction
// - lower-case main instruction means checked request and checked answer
// - a percent character marks the start of a device address
// - one host talks to one device, no station arbitration
// - request check is low byte of sum enquiry through end, two hex chars
// - answer check is low byte of sum header through end-of-text
// - block count holds one to sixteen, two hex chars
`timescale 1ns/1ps
`default_nettype none
module acf_frames (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic RX_VALID,
	input wire logic [7:0] RX_DATA,
	output logic PAY_VALID,
	output acf_pkg::acf_pay_t PAY,
	output logic CMD_VALID,
	output acf_pkg::acf_cmd_t CMD,
	input wire logic RSP_VALID,
	input wire acf_pkg::acf_rsp_t RSP,
	output logic RSP_READY,
	output logic TX_VALID,
	output logic [7:0] TX_DATA,
	input wire logic TX_READY
);
	typedef enum logic [3:0] {
		R_IDLE = 4'b0000,
		R_STN0 = 4'b0001,
		R_STN1 = 4'b0010,
		R_MAIN = 4'b0011,
		R_TYP0 = 4'b0100,
		R_TYP1 = 4'b0101,
		R_BODY = 4'b0110,
		R_BCC0 = 4'b0111,
		R_BCC1 = 4'b1000,
		R_WAIT = 4'b1001
	} acf_rx_state_t;

	typedef enum logic [3:0] {
		T_IDLE = 4'b0000,
		T_HDR = 4'b0001,
		T_STN0 = 4'b0010,
		T_STN1 = 4'b0011,
		T_MAIN = 4'b0100,
		T_TYP0 = 4'b0101,
		T_TYP1 = 4'b0110,
		T_BODY = 4'b0111,
		T_ETX = 4'b1000,
		T_BCC0 = 4'b1001,
		T_BCC1 = 4'b1010
	} acf_tx_state_t;

	////////////////////////////////////////////////////////////////////////////////
	// request side

	acf_rx_state_t rx_state_q, rx_state_d;
	acf_pkg::acf_cmd_t cmd_q, cmd_d;
	logic cmd_valid_q, cmd_valid_d;
	acf_pkg::acf_pay_t pay_q, pay_d;
	logic pay_valid_q, pay_valid_d;
	logic [1:0] body_cnt_q, body_cnt_d;
	logic [7:0] bcc_hi_q, bcc_hi_d;
	logic rsum_load;
	logic rsum_add;
	logic [7:0] rsum;
	logic finish;
	logic [7:0] ch_up;
	logic [7:0] main_up;
	logic [15:0] typ_code;
	logic needs_blocks;
	logic tx_done;

	acf_fcs u_rx_fcs (
		.clk(MCLK),
		.rst(RST),
		.load(rsum_load),
		.add(rsum_add),
		.data(RX_DATA),
		.sum(rsum)
	);

	always_comb begin
		rx_state_d = rx_state_q;
		cmd_d = cmd_q;
		cmd_valid_d = 1'b0;
		pay_d = pay_q;
		pay_valid_d = 1'b0;
		body_cnt_d = body_cnt_q;
		bcc_hi_d = bcc_hi_q;
		rsum_load = 1'b0;
		rsum_add = 1'b0;
		finish = 1'b0;
		ch_up = acf_pkg::to_upper(RX_DATA);
		main_up = acf_pkg::to_upper(cmd_q.main);
		typ_code = {cmd_q.typ[15:8], ch_up};
		needs_blocks = (cmd_q.op == acf_pkg::OP_READ_SINGLE_CMD)
			|| (cmd_q.op == acf_pkg::OP_READ_BLOCK_CMD)
			|| (cmd_q.op == acf_pkg::OP_WRITE_SINGLE_CMD)
			|| (cmd_q.op == acf_pkg::OP_WRITE_BLOCK_CMD);
		// bytes come whole from the character receiver in the agreed format
		if (RX_VALID && (rx_state_q != R_WAIT) && (RX_DATA == acf_pkg::CH_ENQ)) begin
			rx_state_d = R_STN0;
			cmd_d = '0;
			body_cnt_d = '0;
			rsum_load = 1'b1;
		end else if (RX_VALID) begin
			unique case (rx_state_q)
				R_IDLE, R_WAIT: begin
					// idle noise and bytes sent while an answer is pending are dropped
				end
				R_STN0: begin
					cmd_d.station[15:8] = ch_up;
					rsum_add = 1'b1;
					rx_state_d = R_STN1;
				end
				R_STN1: begin
					cmd_d.station[7:0] = ch_up;
					rsum_add = 1'b1;
					rx_state_d = R_MAIN;
				end
				R_MAIN: begin
					rsum_add = 1'b1;
					cmd_d.main = RX_DATA;
					cmd_d.checked = acf_pkg::is_lower(RX_DATA);
					rx_state_d = R_BODY;
					if ((ch_up == acf_pkg::INS_READ) || (ch_up == acf_pkg::INS_WRITE)) begin
						rx_state_d = R_TYP0;
					end else if (ch_up == acf_pkg::INS_MON_REG) begin
						cmd_d.op = acf_pkg::OP_MON_REGISTER;
					end else if (ch_up == acf_pkg::INS_MON_RUN) begin
						cmd_d.op = acf_pkg::OP_MON_EXECUTE;
					end else begin
						cmd_d.fault = 1'b1;
						cmd_d.err = acf_pkg::ERR_INSTR;
					end
				end
				R_TYP0: begin
					cmd_d.typ[15:8] = ch_up;
					rsum_add = 1'b1;
					rx_state_d = R_TYP1;
				end
				R_TYP1: begin
					cmd_d.typ[7:0] = ch_up;
					rsum_add = 1'b1;
					rx_state_d = R_BODY;
					if (typ_code == acf_pkg::TYP_SINGLE) begin
						cmd_d.op = (main_up == acf_pkg::INS_READ) ? acf_pkg::OP_READ_SINGLE_CMD
							: acf_pkg::OP_WRITE_SINGLE_CMD;
					end else if (typ_code == acf_pkg::TYP_BLOCK) begin
						cmd_d.op = (main_up == acf_pkg::INS_READ) ? acf_pkg::OP_READ_BLOCK_CMD
							: acf_pkg::OP_WRITE_BLOCK_CMD;
					end else if ((typ_code == acf_pkg::TYP_STATUS)
						&& (main_up == acf_pkg::INS_READ)) begin
						cmd_d.op = acf_pkg::OP_STATUS;
					end else begin
						cmd_d.fault = 1'b1;
						cmd_d.err = acf_pkg::ERR_TYPE;
					end
				end
				R_BODY: begin
					rsum_add = 1'b1;
					if (RX_DATA == acf_pkg::CH_EOT) begin
						if (cmd_q.checked) begin
							rx_state_d = R_BCC0;
						end else begin
							finish = 1'b1;
						end
					end else begin
						pay_valid_d = 1'b1;
						pay_d.data = ch_up;
						pay_d.addr_start = (RX_DATA == acf_pkg::CH_PCT);
						if (needs_blocks && (body_cnt_q != acf_pkg::BLK_CHARS)) begin
							body_cnt_d = body_cnt_q + 2'h1;
							cmd_d.blocks = {cmd_q.blocks[3:0], acf_pkg::hex_val(ch_up)};
							if (!acf_pkg::is_hex(ch_up) && !cmd_q.fault) begin
								cmd_d.fault = 1'b1;
								cmd_d.err = acf_pkg::ERR_BLOCKS;
							end
						end
					end
				end
				R_BCC0: begin
					bcc_hi_d = ch_up;
					rx_state_d = R_BCC1;
				end
				R_BCC1: begin
					finish = 1'b1;
					if (((bcc_hi_q != acf_pkg::hex_char(rsum[7:4]))
						|| (ch_up != acf_pkg::hex_char(rsum[3:0]))) && !cmd_q.fault) begin
						cmd_d.fault = 1'b1;
						cmd_d.err = acf_pkg::ERR_CHECK;
					end
				end
			endcase
		end
		if (finish) begin
			if (needs_blocks && !cmd_d.fault && ((body_cnt_q != acf_pkg::BLK_CHARS)
				|| (cmd_q.blocks < acf_pkg::BLK_MIN) || (cmd_q.blocks > acf_pkg::BLK_MAX))) begin
				cmd_d.fault = 1'b1;
				cmd_d.err = acf_pkg::ERR_BLOCKS;
			end
			cmd_valid_d = 1'b1;
			rx_state_d = R_WAIT;
		end
		// half duplex with a single host: the next request waits for the answer
		if ((rx_state_q == R_WAIT) && tx_done) begin
			rx_state_d = R_IDLE;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			rx_state_q <= R_IDLE;
			cmd_q <= '0;
			cmd_valid_q <= 1'b0;
			pay_q <= '0;
			pay_valid_q <= 1'b0;
			body_cnt_q <= '0;
			bcc_hi_q <= 8'h00;
		end else begin
			rx_state_q <= rx_state_d;
			cmd_q <= cmd_d;
			cmd_valid_q <= cmd_valid_d;
			pay_q <= pay_d;
			pay_valid_q <= pay_valid_d;
			body_cnt_q <= body_cnt_d;
			bcc_hi_q <= bcc_hi_d;
		end
	end

	assign CMD = cmd_q;
	assign CMD_VALID = cmd_valid_q;
	assign PAY = pay_q;
	assign PAY_VALID = pay_valid_q;

	////////////////////////////////////////////////////////////////////////////////
	// answer side

	acf_tx_state_t tx_state_q, tx_state_d;
	logic tx_valid_q, tx_valid_d;
	logic [7:0] tx_data_q, tx_data_d;
	logic self_nak_q, self_nak_d;
	logic [1:0] err_idx_q, err_idx_d;
	logic slot_free;
	logic go;
	logic [7:0] tb;
	logic tsum_load;
	logic tsum_add;
	logic [7:0] tsum;
	logic [3:0] err_nib;
	logic has_typ;

	acf_fcs u_tx_fcs (
		.clk(MCLK),
		.rst(RST),
		.load(tsum_load),
		.add(tsum_add),
		.data(tb),
		.sum(tsum)
	);

	always_comb begin
		tx_state_d = tx_state_q;
		self_nak_d = self_nak_q;
		err_idx_d = err_idx_q;
		slot_free = !tx_valid_q || TX_READY;
		tx_valid_d = tx_valid_q && !TX_READY;
		tx_data_d = tx_data_q;
		go = 1'b0;
		tb = 8'h00;
		tsum_load = 1'b0;
		tsum_add = 1'b0;
		tx_done = 1'b0;
		RSP_READY = 1'b0;
		has_typ = (acf_pkg::to_upper(cmd_q.main) == acf_pkg::INS_READ)
			|| (acf_pkg::to_upper(cmd_q.main) == acf_pkg::INS_WRITE);
		unique case (err_idx_q)
			2'h0: err_nib = cmd_q.err[15:12];
			2'h1: err_nib = cmd_q.err[11:8];
			2'h2: err_nib = cmd_q.err[7:4];
			2'h3: err_nib = cmd_q.err[3:0];
		endcase
		unique case (tx_state_q)
			T_IDLE: begin
				if (cmd_valid_q) begin
					self_nak_d = cmd_q.fault;
					err_idx_d = '0;
					tx_state_d = T_HDR;
				end
			end
			T_HDR: begin
				// the user's first answer byte tells whether it accepts the request
				go = slot_free && (self_nak_q || RSP_VALID);
				tb = (self_nak_q || RSP.nak) ? acf_pkg::CH_NAK : acf_pkg::CH_ACK;
				tsum_load = go;
				if (go) begin
					tx_state_d = T_STN0;
				end
			end
			T_STN0: begin
				go = slot_free;
				tb = cmd_q.station[15:8];
				tx_state_d = go ? T_STN1 : T_STN0;
			end
			T_STN1: begin
				go = slot_free;
				tb = cmd_q.station[7:0];
				tx_state_d = go ? T_MAIN : T_STN1;
			end
			T_MAIN: begin
				go = slot_free;
				tb = cmd_q.main;
				if (go) begin
					tx_state_d = has_typ ? T_TYP0 : T_BODY;
				end
			end
			T_TYP0: begin
				go = slot_free;
				tb = cmd_q.typ[15:8];
				tx_state_d = go ? T_TYP1 : T_TYP0;
			end
			T_TYP1: begin
				go = slot_free;
				tb = cmd_q.typ[7:0];
				tx_state_d = go ? T_BODY : T_TYP1;
			end
			T_BODY: begin
				if (self_nak_q) begin
					go = slot_free;
					tb = acf_pkg::hex_char(err_nib);
					if (go) begin
						err_idx_d = err_idx_q + 2'h1;
						if (err_idx_q == acf_pkg::ERR_LAST) begin
							tx_state_d = T_ETX;
						end
					end
				end else begin
					go = slot_free && RSP_VALID;
					RSP_READY = slot_free;
					tb = RSP.data;
					if (go && RSP.last) begin
						tx_state_d = T_ETX;
					end
				end
			end
			T_ETX: begin
				go = slot_free;
				tb = acf_pkg::CH_ETX;
				if (go) begin
					tx_state_d = cmd_q.checked ? T_BCC0 : T_IDLE;
					tx_done = !cmd_q.checked;
				end
			end
			T_BCC0: begin
				go = slot_free;
				tb = acf_pkg::hex_char(tsum[7:4]);
				tx_state_d = go ? T_BCC1 : T_BCC0;
			end
			T_BCC1: begin
				go = slot_free;
				tb = acf_pkg::hex_char(tsum[3:0]);
				if (go) begin
					tx_state_d = T_IDLE;
					tx_done = 1'b1;
				end
			end
			default: begin
				tx_state_d = T_IDLE;
			end
		endcase
		// the check covers header through end-of-text, never the check chars
		if (go && (tx_state_q != T_HDR) && (tx_state_q != T_BCC0) && (tx_state_q != T_BCC1)) begin
			tsum_add = 1'b1;
		end
		if (go) begin
			tx_valid_d = 1'b1;
			tx_data_d = tb;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			tx_state_q <= T_IDLE;
			tx_valid_q <= 1'b0;
			tx_data_q <= 8'h00;
			self_nak_q <= 1'b0;
			err_idx_q <= '0;
		end else begin
			tx_state_q <= tx_state_d;
			tx_valid_q <= tx_valid_d;
			tx_data_q <= tx_data_d;
			self_nak_q <= self_nak_d;
			err_idx_q <= err_idx_d;
		end
	end

	assign TX_VALID = tx_valid_q;
	assign TX_DATA = tx_data_q;
endmodule
`default_nettype wire

// ### acf_frames_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module acf_frames_chk (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic RX_VALID,
	input wire logic [7:0] RX_DATA,
	input wire logic PAY_VALID,
	input wire acf_pkg::acf_pay_t PAY,
	input wire logic CMD_VALID,
	input wire acf_pkg::acf_cmd_t CMD,
	input wire logic RSP_VALID,
	input wire acf_pkg::acf_rsp_t RSP,
	input wire logic RSP_READY,
	input wire logic TX_VALID,
	input wire logic [7:0] TX_DATA,
	input wire logic TX_READY
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);
	////////////////////////////////////////
	sequence nak_head;
		TX_VALID && TX_DATA == acf_pkg::CH_NAK;
	endsequence
	sequence etx_sent;
		TX_VALID && TX_READY && TX_DATA == acf_pkg::CH_ETX;
	endsequence
	logic [7:0] up_main;
	assign up_main = CMD.main & 8'hDF;
	////////////////////////////////////////
	self_nak_a: assert property (CMD_VALID && CMD.fault |-> ##2 nak_head ##[1:300] etx_sent)
		else $error("self answer framing wrong");
	cmd_pulse_a: assert property (CMD_VALID |=> (!CMD_VALID && $stable(CMD)) [*4])
		else $error("command pulse or hold wrong");
	tx_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
		else $error("tx byte dropped while stalled");
	pay_case_a: assert property (PAY_VALID |-> !(PAY.data inside {[8'h61:8'h7A]}))
		else $error("payload not upper case");
	addr_mark_a: assert property (PAY_VALID |-> PAY.addr_start == (PAY.data == 8'h25))
		else $error("address start flag wrong");
	// only a lower-case letter selects the check, a digit with bit 5 set does not
	check_sel_a: assert property (CMD_VALID |-> CMD.checked == (CMD.main inside {[8'h61:8'h7A]}))
		else $error("checked flag wrong");
	op_read_a: assert property (
		CMD_VALID && !CMD.fault && CMD.op inside {3'h1, 3'h2, 3'h7}
		|-> up_main == 8'h52 && CMD.typ == (CMD.op == 3'h1 ? 16'h5353 :
		CMD.op == 3'h2 ? 16'h5342 : 16'h5354))
		else $error("read op decode wrong");
	op_write_a: assert property (
		CMD_VALID && !CMD.fault && CMD.op inside {3'h3, 3'h4}
		|-> up_main == 8'h57 && CMD.typ == (CMD.op == 3'h3 ? 16'h5353 : 16'h5342))
		else $error("write op decode wrong");
	op_mon_a: assert property (
		CMD_VALID && !CMD.fault && CMD.op inside {3'h5, 3'h6}
		|-> up_main == (CMD.op == 3'h5 ? 8'h58 : 8'h59))
		else $error("monitor op decode wrong");
	blk_range_a: assert property (
		CMD_VALID && !CMD.fault && CMD.op inside {[3'h1:3'h4]}
		|-> CMD.blocks inside {[8'h01:8'h10]})
		else $error("block count out of range");
endmodule
bind acf_frames acf_frames_chk chk (.MCLK(MCLK), .RST(RST), .RX_VALID(RX_VALID),
	.RX_DATA(RX_DATA), .PAY_VALID(PAY_VALID), .PAY(PAY), .CMD_VALID(CMD_VALID), .CMD(CMD),
	.RSP_VALID(RSP_VALID), .RSP(RSP), .RSP_READY(RSP_READY), .TX_VALID(TX_VALID),
	.TX_DATA(TX_DATA), .TX_READY(TX_READY));
`default_nettype wire

// ### acf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module acf_host_model (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic TX_VALID,
	input wire logic [7:0] TX_DATA,
	output logic RX_VALID,
	output logic [7:0] RX_DATA,
	output logic TX_READY
);
	initial begin
		RX_VALID = 1'b0;
		RX_DATA = 8'hA5;
		TX_READY = 1'b0;
	end
	// a slow reader stalls about one byte in three, so the hold logic is exercised
	always @(posedge MCLK) begin
		TX_READY <= !RST && ($urandom % 3 != 0);
	end
	////////////////////////////////////////
	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
	endfunction
	// idle data shows the inverse, never a stale copy of the last byte
	task automatic send(input logic [7:0] b);
		@(posedge MCLK);
		RX_VALID <= 1'b1;
		RX_DATA <= b;
		@(posedge MCLK);
		RX_VALID <= 1'b0;
		RX_DATA <= ~b;
	endtask
	task automatic req(input logic [7:0] m, input logic [15:0] t, input logic [7:0] n,
		input logic bad);
		logic [7:0] q[$];
		logic [7:0] s;
		q = {acf_pkg::CH_ENQ, 8'h32, 8'h30, m};
		if (t != 16'h0000) q = {q, t[15:8] | 8'h20, t[7:0] | 8'h20};
		if (t == 16'h5353 || t == 16'h5342) q = {q, hx(n[7:4]), hx(n[3:0])};
		q = {q, 8'h25, 8'h6D, 8'h78, 8'h31, 8'h46, acf_pkg::CH_EOT};
		s = {7'h00, bad};
		foreach (q[i]) s += q[i];
		if (m[5]) q = {q, hx(s[7:4]), hx(s[3:0])};
		foreach (q[i]) send(q[i]);
	endtask
endmodule
`default_nettype wire

// ### ascii_serial_command_frames_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("mismatch at %0t: %h vs %h", $time, (g), (e)); end end
module ascii_serial_command_frames_tb_top;
	logic MCLK = 1'b0;
	logic RST = 1'b1;
	logic RX_VALID, PAY_VALID, CMD_VALID, RSP_VALID, RSP_READY, TX_VALID, TX_READY;
	logic [7:0] RX_DATA, TX_DATA;
	acf_pkg::acf_pay_t PAY;
	acf_pkg::acf_cmd_t CMD;
	acf_pkg::acf_rsp_t RSP;
	logic [7:0] tx_q[$];
	logic [28:0] cmd_q[$];
	logic [8:0] pay_exp[$];
	logic [28:0] ec;
	logic [28:0] gc;
	logic [8:0] ep;
	logic [7:0] et;
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	always #4 MCLK = ~MCLK;
	acf_frames dut (.MCLK(MCLK), .RST(RST), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
		.PAY_VALID(PAY_VALID), .PAY(PAY), .CMD_VALID(CMD_VALID), .CMD(CMD),
		.RSP_VALID(RSP_VALID), .RSP(RSP), .RSP_READY(RSP_READY), .TX_VALID(TX_VALID),
		.TX_DATA(TX_DATA), .TX_READY(TX_READY));
	acf_host_model host (.MCLK(MCLK), .RST(RST), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
		.RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .TX_READY(TX_READY));
	////////////////////////////////////////
	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
	endfunction
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// faulty commands carry no trustworthy op, clean ones no trustworthy code
	task automatic run(input logic [7:0] m, input logic [15:0] t, input logic [7:0] n,
		input logic bad, input logic [2:0] op, input logic [15:0] err);
		logic [7:0] q[$];
		logic [7:0] s;
		logic [7:0] ans;
		logic nk;
		int k;
		int nb;
		ans = 8'h41 + 8'($urandom % 26);
		nk = (err != 16'h0000) || ($urandom % 2 == 1);
		// a two-byte answer also covers a user byte that is not the last
		nb = 1 + $urandom % 2;
		cmd_q.push_back({m[5], op, err != 16'h0000, err, ((err != 16'h0000) ? 8'h00 : n)});
		if (t == 16'h5353 || t == 16'h5342) begin
			pay_exp.push_back({hx(n[7:4]), 1'b0});
			pay_exp.push_back({hx(n[3:0]), 1'b0});
		end
		pay_exp.push_back({8'h25, 1'b1});
		pay_exp.push_back({8'h4D, 1'b0});
		pay_exp.push_back({8'h58, 1'b0});
		pay_exp.push_back({8'h31, 1'b0});
		pay_exp.push_back({8'h46, 1'b0});
		q = {nk ? acf_pkg::CH_NAK : acf_pkg::CH_ACK, 8'h32, 8'h30, m};
		if ((m & 8'hDF) == 8'h52 || (m & 8'hDF) == 8'h57) q = {q, t[15:8], t[7:0]};
		if (err != 16'h0000) q = {q, hx(err[15:12]), hx(err[11:8]), hx(err[7:4]), hx(err[3:0])};
		else begin
			q.push_back(ans);
			if (nb == 2) q.push_back(ans + 8'h01);
		end
		q.push_back(acf_pkg::CH_ETX);
		s = 8'h00;
		foreach (q[i]) s += q[i];
		if (m[5]) q = {q, hx(s[7:4]), hx(s[3:0])};
		tx_q = {tx_q, q};
		host.req(m, t, n, bad);
		k = 0;
		do begin
			@(negedge MCLK);
			k++;
		end while (CMD_VALID !== 1'b1 && k < 200);
		if (err == 16'h0000) begin
			@(posedge MCLK);
			for (k = 0; k < nb; k++) begin
				RSP_VALID <= 1'b1;
				RSP <= '{data: ans + 8'(k), last: (k == nb - 1), nak: nk};
				do @(negedge MCLK); while (RSP_READY !== 1'b1);
				@(posedge MCLK);
			end
			RSP_VALID <= 1'b0;
		end
		while (tx_q.size() != 0) @(negedge MCLK);
		repeat (3) @(posedge MCLK);
	endtask
	////////////////////////////////////////
	always @(negedge MCLK) begin
		if (!RST && CMD_VALID) begin
			ec = (cmd_q.size() != 0) ? cmd_q.pop_front() : 29'h1FFFFFFF;
			gc = {CMD.checked, CMD.fault ? 3'h0 : CMD.op, CMD.fault, CMD.fault ? CMD.err : 16'h0,
				CMD.fault ? 8'h00 : CMD.blocks};
			`CHK(gc, ec)
		end
		if (!RST && PAY_VALID) begin
			ep = (pay_exp.size() != 0) ? pay_exp.pop_front() : ~PAY;
			`CHK(PAY, ep)
		end
		if (!RST && TX_VALID && TX_READY) begin
			et = (tx_q.size() != 0) ? tx_q.pop_front() : ~TX_DATA;
			`CHK(TX_DATA, et)
		end
	end
	always @(posedge MCLK) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			give_verdict();
		end
	end
	initial begin
		RSP_VALID = 1'b0;
		RSP = '0;
		void'($urandom(32'hED10C655));
		repeat (4) @(posedge MCLK);
		RST <= 1'b0;
		host.send(acf_pkg::CH_ENQ);
		host.send(8'h32);
		run(8'h52, 16'h5353, 8'h01, 1'b0, 3'h1, 16'h0000);
		run(8'h72, 16'h5342, 8'h10, 1'b0, 3'h2, 16'h0000);
		run(8'h57, 16'h5353, 8'h01, 1'b0, 3'h3, 16'h0000);
		run(8'h77, 16'h5342, 8'h01, 1'b0, 3'h4, 16'h0000);
		run(8'h78, 16'h0000, 8'h00, 1'b0, 3'h5, 16'h0000);
		run(8'h59, 16'h0000, 8'h00, 1'b0, 3'h6, 16'h0000);
		run(8'h52, 16'h5354, 8'h00, 1'b0, 3'h7, 16'h0000);
		run(8'h52, 16'h5353, 8'h11, 1'b0, 3'h0, acf_pkg::ERR_BLOCKS);
		run(8'h72, 16'h5342, 8'h00, 1'b0, 3'h0, acf_pkg::ERR_BLOCKS);
		run(8'h72, 16'h5353, 8'h01, 1'b1, 3'h0, acf_pkg::ERR_CHECK);
		run(8'h51, 16'h0000, 8'h00, 1'b0, 3'h0, acf_pkg::ERR_INSTR);
		run(8'h57, 16'h5354, 8'h00, 1'b0, 3'h0, acf_pkg::ERR_TYPE);
		give_verdict();
	end
endmodule
`default_nettype wire
